// ===== core/dram_ctrl_pkg.sv
// Shared constants, commands and carriers for the page-mode DRAM controller
package dram_ctrl_pkg;

    localparam int CLK_PERIOD_NS = 20;

    // Minimum and maximum times in their own units (slow grade figures)
    localparam int POWERUP_WAIT_US  = 200;
    localparam int WAKEUP_CYCLES    = 8;
    localparam int REFRESH_ROWS     = 1024;
    localparam int REFRESH_PERIOD_MS = 16;
    localparam int CYCLE_TIME_NS    = 110;
    localparam int ROW_PRECHARGE_NS = 40;
    localparam int ROW_PULSE_NS     = 60;
    localparam int ROW_PULSE_MAX_NS = 100000;
    localparam int COL_PRECHARGE_NS = 10;
    localparam int COL_PULSE_NS     = 15;
    localparam int ROW_TO_COL_NS    = 20;
    localparam int ROW_ACCESS_NS    = 60;
    localparam int COL_ACCESS_NS    = 15;
    localparam int ADDR_ACCESS_NS   = 30;
    localparam int PAGE_CYCLE_NS    = 25;
    localparam int WRITE_DATA_HOLD_NS = 10;
    localparam int GATE_HOLD_AFTER_WRITE_NS = 15;
    localparam int GATE_OUTPUT_DISABLE_NS = 15;
    localparam int COLUMN_TO_WRITE_DELAY_NS = 36;
    localparam int ROW_TO_WRITE_DELAY_NS = 80;
    localparam int REFRESH_COL_SETUP_NS = 10;
    localparam int REFRESH_COLUMN_HOLD_NS = 10;

    function automatic int min_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int max_cycles(input int ns);
        int c;
        c = ns / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int POWERUP_CYC   = (POWERUP_WAIT_US * 1000 + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int REFRESH_INTERVAL_CYC =
        (REFRESH_PERIOD_MS * 1000000 / CLK_PERIOD_NS) / REFRESH_ROWS;
    localparam int ROW_PRECHARGE_CYC = min_cycles(ROW_PRECHARGE_NS);
    localparam int ROW_PULSE_CYC    = min_cycles(ROW_PULSE_NS);
    localparam int ROW_PULSE_MAX_CYC = max_cycles(ROW_PULSE_MAX_NS);
    localparam int COL_PRECHARGE_CYC = min_cycles(COL_PRECHARGE_NS);
    localparam int ROW_TO_COL_CYC   = min_cycles(ROW_TO_COL_NS);
    localparam int ACCESS_CYC       = min_cycles(ROW_ACCESS_NS);
    localparam int COL_LOW_CYC      = min_cycles(ADDR_ACCESS_NS);
    localparam int GATE_HOLD_CYC    = min_cycles(GATE_HOLD_AFTER_WRITE_NS);
    localparam int WRITE_DELAY_CYC  = min_cycles(COLUMN_TO_WRITE_DELAY_NS);
    localparam int REFRESH_SETUP_CYC = min_cycles(REFRESH_COL_SETUP_NS);
    localparam int REFRESH_HOLD_CYC = min_cycles(REFRESH_COLUMN_HOLD_NS);
    localparam int CYCLE_CYC        = min_cycles(CYCLE_TIME_NS);

    localparam int ROW_BITS  = 10;
    localparam int COL_BITS  = 9;
    localparam int ADDR_BITS = 19;
    localparam int DATA_BITS = 8;
    localparam int CNT_BITS  = 16;

    typedef enum logic [1:0] {
        OP_READ,
        OP_EARLY_WRITE,
        OP_LATE_WRITE,
        OP_READ_MODIFY_WRITE
    } op_e;

    typedef struct packed {
        op_e                  op;
        logic [ADDR_BITS-1:0] addr;
        logic [DATA_BITS-1:0] wdata;
    } request_s;

    typedef struct packed {
        logic                 row_strobe_n;
        logic                 col_strobe_n;
        logic                 write_strobe_n;
        logic                 out_gate_n;
        logic [ROW_BITS-1:0]  mux_address_pins;
        logic [DATA_BITS-1:0] data_out;
        logic                 data_oe;
    } dram_pins_s;

endpackage

// ===== core/dram_delay_timer.sv
// Down-counting delay timer used to pace strobe edges
module dram_delay_timer
    import dram_ctrl_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                nrst,
    input  wire logic                load,
    input  wire logic [CNT_BITS-1:0] count,
    output logic                     done
);

    logic [CNT_BITS-1:0] remain;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            remain <= '0;
        end else if (load) begin
            remain <= count;
        end else if (remain != '0) begin
            remain <= remain - 16'h0001;
        end
    end

    // A load of N makes done rise N edges later; done ignores load so that
    // callers may load on done without closing a combinational loop
    assign done = (remain == '0);

endmodule

// ===== core/dram_page_ctrl.sv
// Controller that drives an asynchronous fast-page-mode DRAM
module dram_page_ctrl
    import dram_ctrl_pkg::*;
#(
    parameter int POWERUP_WAIT   = POWERUP_CYC,
    parameter int REFRESH_PERIOD = REFRESH_INTERVAL_CYC
)(
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire logic                 req_valid,
    input  wire request_s             req,
    output logic                      req_ready,
    output logic                      rsp_valid,
    output logic [DATA_BITS-1:0]      rsp_data,
    output logic                      init_done,
    output logic                      row_strobe_n,
    output logic                      col_strobe_n,
    output logic                      write_strobe_n,
    output logic                      out_gate_n,
    output logic [ROW_BITS-1:0]       mux_address_pins,
    output logic [DATA_BITS-1:0]      byte_data_bus_out,
    output logic                      byte_data_bus_oe,
    input  wire logic [DATA_BITS-1:0] byte_data_bus_in
);

    typedef enum logic [3:0] {
        ST_POWERUP,
        ST_IDLE,
        ST_REF_COL,
        ST_REF_ROW,
        ST_ROW,
        ST_COL,
        ST_WRITE_LATE,
        ST_GATE_HOLD,
        ST_CLOSE
    } state_e;

    state_e              state;
    request_s            cur;
    dram_pins_s          pins;
    logic                load;
    logic [CNT_BITS-1:0] count;
    logic                timer_done;
    logic [3:0]          wake_left;
    logic                ref_due;
    logic                ref_overdue;
    logic                ref_served;
    logic                running;
    logic [DATA_BITS-1:0] data_s1;
    logic [DATA_BITS-1:0] data_s2;
    logic                in_wake;
    logic                pwr_armed;
    logic                rd_wait;

    function automatic logic [CNT_BITS-1:0] cyc(input int n);
        return CNT_BITS'(n);
    endfunction

    dram_delay_timer u_timer (
        .clk   (clk),
        .nrst  (nrst),
        .load  (load),
        .count (count),
        .done  (timer_done)
    );

    dram_refresh_tick #(
        .INTERVAL (REFRESH_PERIOD)
    ) u_refresh (
        .clk     (clk),
        .nrst    (nrst),
        .enable  (running),
        .served  (ref_served),
        .due     (ref_due),
        .overdue (ref_overdue)
    );

    // Data pins come from the far chip, so synchronise before sampling
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            data_s1 <= '0;
            data_s2 <= '0;
        end else begin
            data_s1 <= byte_data_bus_in;
            data_s2 <= data_s1;
        end
    end

    assign ref_served = (state == ST_REF_COL) && timer_done && running;
    assign in_wake    = wake_left != 4'h0;

    // Timer loads are issued on every state change except ST_CLOSE to ST_IDLE, with the next delay
    always_comb begin
        load  = 1'b0;
        count = '0;
        case (state)
            ST_POWERUP: begin
                load  = !pwr_armed || timer_done;
                count = pwr_armed ? cyc(REFRESH_SETUP_CYC)
                                  : cyc(POWERUP_WAIT);
            end
            ST_IDLE: begin
                load  = ref_due || !running || in_wake || req_valid;
                count = (ref_due || !running || in_wake)
                        ? cyc(REFRESH_SETUP_CYC) : cyc(ROW_TO_COL_CYC);
            end
            ST_REF_COL: begin
                load  = timer_done;
                count = cyc(ROW_PULSE_CYC);
            end
            ST_REF_ROW: begin
                load  = timer_done;
                count = cyc(ROW_PRECHARGE_CYC);
            end
            ST_ROW: begin
                load  = timer_done;
                count = cyc(COL_LOW_CYC);
            end
            ST_COL: begin
                load  = timer_done;
                count = (cur.op == OP_READ || cur.op == OP_EARLY_WRITE)
                        ? cyc(ROW_PRECHARGE_CYC) : cyc(WRITE_DELAY_CYC);
            end
            ST_WRITE_LATE: begin
                load  = timer_done;
                count = cyc(GATE_HOLD_CYC);
            end
            ST_GATE_HOLD: begin
                load  = timer_done;
                count = cyc(ROW_PRECHARGE_CYC);
            end
            default: begin
                load  = 1'b0;
                count = '0;
            end
        endcase
    end

    // Power-up pause, then wake-up refreshes before any access
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            running   <= 1'b0;
            wake_left <= 4'h0;
            pwr_armed <= 1'b0;
        end else if (!pwr_armed) begin
            pwr_armed <= 1'b1;
        end else if (state == ST_POWERUP && timer_done && !running) begin
            running   <= 1'b1;
            wake_left <= 4'(WAKEUP_CYCLES);
        end else if (ref_overdue && state == ST_IDLE) begin
            wake_left <= 4'(WAKEUP_CYCLES);
        end else if (state == ST_CLOSE && wake_left != 4'h0 && timer_done
                     && cur.op == OP_READ && pins.col_strobe_n) begin
            wake_left <= wake_left - 4'h1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_POWERUP;
        end else begin
            case (state)
                ST_POWERUP: begin
                    if (timer_done && running) begin
                        state <= ST_REF_COL;
                    end
                end
                ST_IDLE: begin
                    if (ref_due || !running || in_wake) begin
                        state <= ST_REF_COL;
                    end else if (req_valid) begin
                        state <= ST_ROW;
                    end
                end
                ST_REF_COL: if (timer_done) state <= ST_REF_ROW;
                ST_REF_ROW: if (timer_done) state <= ST_CLOSE;
                ST_ROW:     if (timer_done) state <= ST_COL;
                ST_COL: begin
                    if (timer_done) begin
                        state <= (cur.op == OP_READ
                                  || cur.op == OP_EARLY_WRITE)
                                 ? ST_CLOSE : ST_WRITE_LATE;
                    end
                end
                ST_WRITE_LATE: if (timer_done) state <= ST_GATE_HOLD;
                ST_GATE_HOLD:  if (timer_done) state <= ST_CLOSE;
                ST_CLOSE: begin
                    // Precharge keeps both strobes high; spacing holds
                    if (timer_done) state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Wake-up count drops once per refresh cycle closed
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cur <= '0;
        end else if (state == ST_IDLE && req_valid && !ref_due && running
                     && !in_wake) begin
            cur <= req;
        end else if (state == ST_REF_COL) begin
            cur.op <= OP_READ;
        end
    end

    // Pin drive per state; only column-first refresh is used
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pins.row_strobe_n     <= 1'b1;
            pins.col_strobe_n     <= 1'b1;
            pins.write_strobe_n   <= 1'b1;
            pins.out_gate_n       <= 1'b1;
            pins.mux_address_pins <= '0;
            pins.data_out         <= '0;
            pins.data_oe          <= 1'b0;
        end else begin
            case (state)
                ST_REF_COL: begin
                    pins.col_strobe_n   <= 1'b0;
                    pins.write_strobe_n <= 1'b1;
                    pins.out_gate_n     <= 1'b1;
                    if (timer_done) pins.row_strobe_n <= 1'b0;
                end
                ST_REF_ROW: if (timer_done) begin
                    pins.row_strobe_n <= 1'b1;
                    pins.col_strobe_n <= 1'b1;
                end
                ST_IDLE: begin
                    if (!(ref_due || !running || in_wake) && req_valid) begin
                        pins.mux_address_pins <=
                            req.addr[ADDR_BITS-1 -: ROW_BITS];
                        pins.row_strobe_n <= 1'b0;
                        pins.write_strobe_n <=
                            !(req.op == OP_EARLY_WRITE);
                        pins.data_out <= req.wdata;
                        pins.data_oe  <= req.op == OP_EARLY_WRITE;
                    end
                end
                ST_ROW: if (timer_done) begin
                    pins.mux_address_pins <=
                        {1'b0, cur.addr[COL_BITS-1:0]};
                    pins.col_strobe_n <= 1'b0;
                    // Gate stays high for late writes to keep bus free
                    pins.out_gate_n <= cur.op == OP_EARLY_WRITE
                                       || cur.op == OP_LATE_WRITE;
                end
                ST_COL: if (timer_done) begin
                    if (cur.op == OP_READ || cur.op == OP_EARLY_WRITE) begin
                        pins.row_strobe_n   <= 1'b1;
                        pins.col_strobe_n   <= 1'b1;
                        pins.out_gate_n     <= 1'b1;
                        pins.write_strobe_n <= 1'b1;
                    end else begin
                        pins.out_gate_n     <= 1'b1;
                    end
                end
                ST_WRITE_LATE: if (timer_done) begin
                    pins.data_out       <= cur.wdata;
                    pins.data_oe        <= 1'b1;
                    pins.write_strobe_n <= 1'b0;
                end
                ST_GATE_HOLD: if (timer_done) begin
                    pins.row_strobe_n   <= 1'b1;
                    pins.col_strobe_n   <= 1'b1;
                    pins.write_strobe_n <= 1'b1;
                end
                ST_CLOSE: begin
                    pins.data_oe <= 1'b0;
                end
                default: begin
                    pins.row_strobe_n <= 1'b1;
                    pins.col_strobe_n <= 1'b1;
                end
            endcase
        end
    end

    // Read data leaves the synchroniser one edge after the ST_COL delay ends (column end on reads, gate rise on read-modify-write)
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rsp_valid <= 1'b0;
            rsp_data  <= '0;
            req_ready <= 1'b0;
            init_done <= 1'b0;
            rd_wait   <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            req_ready <= state == ST_IDLE && req_valid && !ref_due
                         && running && !in_wake && !req_ready;
            init_done <= running && !in_wake;
            rd_wait   <= state == ST_COL && timer_done
                         && (cur.op == OP_READ
                             || cur.op == OP_READ_MODIFY_WRITE);
            if (rd_wait) begin
                rsp_valid <= 1'b1;
                rsp_data  <= data_s2;
            end
        end
    end

    assign row_strobe_n      = pins.row_strobe_n;
    assign col_strobe_n      = pins.col_strobe_n;
    assign write_strobe_n    = pins.write_strobe_n;
    assign out_gate_n        = pins.out_gate_n;
    assign mux_address_pins  = pins.mux_address_pins;
    assign byte_data_bus_out = pins.data_out;
    assign byte_data_bus_oe  = pins.data_oe;

endmodule

// ===== core/dram_refresh_tick.sv
// Refresh pacing: one request per row interval, sticky until served
module dram_refresh_tick
    import dram_ctrl_pkg::*;
#(
    parameter int INTERVAL = REFRESH_INTERVAL_CYC
)(
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic enable,
    input  wire logic served,
    output logic      due,
    output logic      overdue
);

    logic [CNT_BITS-1:0] ticks;
    logic                tick;

    assign tick = enable && (ticks == CNT_BITS'(INTERVAL - 1));

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ticks <= '0;
        end else if (!enable || tick) begin
            ticks <= '0;
        end else begin
            ticks <= ticks + 16'h0001;
        end
    end

    // New tick wins over the serve of the previous one
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            due     <= 1'b0;
            overdue <= 1'b0;
        end else begin
            if (tick) begin
                due <= 1'b1;
            end else if (served) begin
                due <= 1'b0;
            end
            // A second tick while one is pending means a row slipped
            if (tick && due && !served) begin
                overdue <= 1'b1;
            end else if (!enable || served) begin
                overdue <= 1'b0;
            end
        end
    end

endmodule

// ===== testbench/dram_ctrl_properties.sv
// Strobe timing assertions for the page-mode DRAM controller
module dram_ctrl_properties
    import dram_ctrl_pkg::*;
(
    input wire logic                clk,
    input wire logic                nrst,
    input wire logic                req_ready,
    input wire logic                init_done,
    input wire logic                row_strobe_n,
    input wire logic                col_strobe_n,
    input wire logic                write_strobe_n,
    input wire logic                out_gate_n,
    input wire logic [ROW_BITS-1:0] mux_address_pins,
    input wire logic                byte_data_bus_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_row_rest;
        row_strobe_n [*2];
    endsequence
    sequence s_row_active;
        !row_strobe_n [*3];
    endsequence
    sequence s_cbr_start;
        $fell(row_strobe_n) && !col_strobe_n;
    endsequence
    AST_NO_EARLY_ACCESS: assert property (!init_done |-> !req_ready)
        else $error("request taken before wake-up finished");
    AST_ROW_PRECHARGE: assert property ($rose(row_strobe_n) |-> s_row_rest)
        else $error("row precharge too short");
    AST_ROW_ACTIVE: assert property ($fell(row_strobe_n) |-> s_row_active)
        else $error("row pulse too short");
    AST_CYCLE_SPACE: assert property (
        $fell(row_strobe_n) && col_strobe_n |=> (!$fell(row_strobe_n)) [*5])
        else $error("row falls closer than the cycle time");
    AST_CBR_SETUP: assert property (s_cbr_start |-> !$past(col_strobe_n))
        else $error("column strobe not set up before refresh");
    AST_CBR_HOLD: assert property (s_cbr_start |=> !col_strobe_n)
        else $error("column strobe not held after refresh");
    AST_READ_NO_WRITE: assert property (
        !row_strobe_n && !col_strobe_n && !out_gate_n && !byte_data_bus_oe
        |-> write_strobe_n)
        else $error("write strobe low during read");
    AST_EARLY_WR_DATA: assert property (
        $fell(col_strobe_n) && !write_strobe_n |-> byte_data_bus_oe [*2])
        else $error("early write data not held");
    AST_LATE_GATE: assert property (
        $fell(write_strobe_n) && !col_strobe_n
        |-> out_gate_n && byte_data_bus_oe ##1 out_gate_n)
        else $error("gate not high around late write");
    AST_COL_ADDR_HOLD: assert property (
        $fell(col_strobe_n) && !row_strobe_n |=> $stable(mux_address_pins))
        else $error("column address not held");
endmodule

bind dram_page_ctrl dram_ctrl_properties chk (
    .clk(clk), .nrst(nrst), .req_ready(req_ready), .init_done(init_done),
    .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
    .write_strobe_n(write_strobe_n), .out_gate_n(out_gate_n),
    .mux_address_pins(mux_address_pins),
    .byte_data_bus_oe(byte_data_bus_oe)
);

// ===== testbench/dram_model.sv
// Behavioural page-mode DRAM answering the controller's strobes
module dram_model
    import dram_ctrl_pkg::*;
(
    input wire logic                 row_strobe_n,
    input wire logic                 col_strobe_n,
    input wire logic                 write_strobe_n,
    input wire logic                 out_gate_n,
    input wire logic [ROW_BITS-1:0]  mux_address_pins,
    input wire logic [DATA_BITS-1:0] data_in,
    output logic [DATA_BITS-1:0]     data_out,
    output logic                     data_oe,
    output int                       wake_cnt,
    output logic                     early_access
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [DATA_BITS-1:0] mem [logic [ADDR_BITS-1:0]];
    logic [ROW_BITS-1:0]  row;
    logic [COL_BITS-1:0]  col;
    logic                 refresh = 1'b0;
    logic                 drive;
    initial begin
        wake_cnt = 0;
        early_access = 1'b0;
        data_oe = 1'b0;
    end
    // Pins change on the same edge as the strobes, so latch just after
    always @(negedge row_strobe_n) begin
        #1;
        refresh = !col_strobe_n;
        if (refresh)
            wake_cnt++;
        else begin
            row = mux_address_pins;
            early_access |= (wake_cnt < WAKEUP_CYCLES);
        end
    end
    always @(negedge col_strobe_n) begin
        #1;
        if (!row_strobe_n && !refresh) begin
            col = mux_address_pins[COL_BITS-1:0];
            if (!write_strobe_n)
                mem[{row, col}] = data_in;
            else
                data_out = mem[{row, col}];
        end
    end
    always @(negedge write_strobe_n) begin
        #1;
        if (!row_strobe_n && !col_strobe_n && !refresh)
            mem[{row, col}] = data_in;
    end
    assign drive = !row_strobe_n && !col_strobe_n && write_strobe_n
                   && !out_gate_n && !refresh;
    // Column address moves with the strobe, so address access sets the delay
    always @(drive)
        data_oe <= #(drive ? ADDR_ACCESS_NS : 3) drive;
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench for the page-mode DRAM controller
module tb_top;
    import dram_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PWR = 20;
    logic                 clk = 1'b0;
    logic                 nrst = 1'b0;
    logic                 req_valid = 1'b0;
    request_s             req = '0;
    logic                 req_ready, rsp_valid, init_done;
    logic [DATA_BITS-1:0] rsp_data, bus_out, bus, m_data, last_bus = '0;
    logic                 rs_n, cs_n, ws_n, og_n, oe, m_oe, m_early;
    logic [ROW_BITS-1:0]  pins;
    int                   m_wake, failures = 0, tests_run = 0;
    int                   cyc = 0, first_fall = -1;

    dram_page_ctrl #(.POWERUP_WAIT(PWR), .REFRESH_PERIOD(200)) dut (
        .clk(clk), .nrst(nrst), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .init_done(init_done), .row_strobe_n(rs_n), .col_strobe_n(cs_n),
        .write_strobe_n(ws_n), .out_gate_n(og_n), .mux_address_pins(pins),
        .byte_data_bus_out(bus_out), .byte_data_bus_oe(oe),
        .byte_data_bus_in(bus));
    dram_model m (
        .row_strobe_n(rs_n), .col_strobe_n(cs_n), .write_strobe_n(ws_n),
        .out_gate_n(og_n), .mux_address_pins(pins), .data_in(bus),
        .data_out(m_data), .data_oe(m_oe), .wake_cnt(m_wake),
        .early_access(m_early));

    // Undriven bus shows the inverse of its last value, never a stale byte
    assign bus = oe ? bus_out : (m_oe ? m_data : ~last_bus);
    always #10 clk = ~clk;
    always @(posedge clk) begin
        last_bus <= bus;
        cyc <= nrst ? cyc + 1 : 0;
        if (nrst && oe && m_oe) begin
            failures++;
            $display("[FAIL] %0t bus driven by both ends", $time);
        end
    end
    always @(negedge rs_n)
        if (nrst && first_fall < 0)
            first_fall = cyc;

    task automatic check(input logic [7:0] got, exp, input string what);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic do_req(input op_e op, input logic [ADDR_BITS-1:0] a,
                          input logic [7:0] d, output logic [7:0] q);
        int n;
        q = '0;
        req_valid = 1'b1;
        req = '{op: op, addr: a, wdata: d};
        for (n = 0; req_ready !== 1'b1 && n < 400; n++)
            @(negedge clk);
        req_valid = 1'b0;
        check(n < 400, 1'b1, "request taken");
        if (op == OP_READ || op == OP_READ_MODIFY_WRITE) begin
            for (n = 0; rsp_valid !== 1'b1 && n < 50; n++)
                @(negedge clk);
            check(n < 50, 1'b1, "response");
            q = rsp_data;
        end
        for (n = 0; !(rs_n === 1'b1 && cs_n === 1'b1) && n < 50; n++)
            @(negedge clk);
    endtask

    task automatic t_init;
        logic [7:0] q;
        do_req(OP_EARLY_WRITE, 19'h00000, 8'h3c, q);
        check(first_fall >= PWR, 1'b1, "power-up pause");
        check(m_early, 1'b0, "access before wake-up");
        check(m_wake >= WAKEUP_CYCLES, 1'b1, "wake-up count");
        $display("test init done");
    endtask

    task automatic t_write_read;
        logic [ADDR_BITS-1:0] a [3] = '{19'h7ffff, 19'h40201, 19'h001ff};
        logic [7:0]           d [3] = '{8'h81, 8'h5a, 8'hc3};
        logic [7:0]           q;
        foreach (a[i]) begin
            do_req(OP_EARLY_WRITE, a[i], d[i], q);
            check(m.mem[a[i]], d[i], "early write stored");
        end
        foreach (a[i]) begin
            do_req(OP_READ, a[i], 8'h00, q);
            check(q, d[i], "read back");
        end
        $display("test write_read done");
    endtask

    task automatic t_late;
        logic [7:0] q;
        do_req(OP_LATE_WRITE, 19'h2aa55, 8'ha5, q);
        check(m.mem[19'h2aa55], 8'ha5, "late write stored");
        do_req(OP_READ, 19'h2aa55, 8'h00, q);
        check(q, 8'ha5, "late write read");
        $display("test late done");
    endtask

    task automatic t_rmw;
        logic [7:0] q;
        do_req(OP_READ_MODIFY_WRITE, 19'h7ffff, 8'h7e, q);
        check(q, 8'h81, "old byte returned");
        check(m.mem[19'h7ffff], 8'h7e, "new byte stored");
        $display("test rmw done");
    endtask

    task automatic t_refresh;
        int w0;
        w0 = m_wake;
        repeat (1000) @(negedge clk);
        check(m_wake - w0 >= 4, 1'b1, "refresh pacing");
        check(m_wake - w0 <= 6, 1'b1, "refresh not flooding");
        $display("test refresh done");
    endtask

    task automatic test_done;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        t_init();
        t_write_read();
        t_late();
        t_rmw();
        t_refresh();
        test_done();
    end

    initial begin
        #400000;
        failures++;
        $display("[FAIL] %0t watchdog expired", $time);
        test_done();
    end
endmodule
